// [shared/udb_pkg.sv]
package udb_pkg;
	// ****************************************
	// Register map (word index on the plain port)
	// ****************************************
	localparam logic [3:0] UDB_OFF_DATA = 4'h0;
	localparam logic [3:0] UDB_OFF_DIV_LO = 4'h1;
	localparam logic [3:0] UDB_OFF_DIV_HI = 4'h2;
	localparam logic [3:0] UDB_OFF_LINE_CTRL = 4'h3;
	localparam logic [3:0] UDB_OFF_FIFO_CTRL = 4'h4;
	localparam logic [3:0] UDB_OFF_SCRATCH = 4'h5;
	localparam logic [3:0] UDB_OFF_IRQ_STATUS = 4'h6;
	localparam logic [3:0] UDB_OFF_IRQ_ENABLE = 4'h7;
	localparam logic [3:0] UDB_OFF_IRQ_CLEAR = 4'h8;
	localparam logic [3:0] UDB_OFF_FIFO_LEVEL = 4'h9;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int UDB_LC_WLEN_LSB = 0;
	localparam int UDB_LC_STOP_BIT = 2;
	localparam int UDB_LC_PAR_EN_BIT = 3;
	localparam int UDB_LC_PAR_EVEN_BIT = 4;
	localparam int UDB_FC_FIFO_EN_BIT = 0;
	localparam int UDB_FC_RX_IRQ_BIT = 1;
	localparam int UDB_FC_TX_IRQ_BIT = 2;
	localparam int UDB_IRQ_RX_BIT = 0;
	localparam int UDB_IRQ_TX_BIT = 1;
	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [15:0] UDB_DIV_RESET = 16'h0001;
	localparam logic [7:0] UDB_LC_RESET = 8'h03;
	localparam logic [7:0] UDB_FC_RESET = 8'h00;
	localparam logic [7:0] UDB_SCRATCH_RESET = 8'h00;
	localparam int UDB_OVERSAMPLE = 16;
	localparam int UDB_FIFO_DEPTH = 16;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} udb_bus_req_t;

	typedef struct packed {
		logic [1:0] wlen;
		logic two_stop;
		logic par_en;
		logic par_even;
	} udb_format_t;

	typedef enum logic [3:0] {
		UDB_IDLE = 4'b0001,
		UDB_START = 4'b0010,
		UDB_DATA = 4'b0100,
		UDB_TAIL = 4'b1000
	} udb_state_t;
endpackage : udb_pkg

// [logic/udb_top.sv]
// Chosen here: strobed register access and the register offsets.
module udb_top
	import udb_pkg::*;
#(
	parameter int DEPTH = UDB_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic rx,
	output logic tx,
	output logic irq
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
			$error("udb_top: DEPTH must be a power of two of at least 2");
		end
	end

	udb_bus_req_t req;
	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [15:0] divisor;
	logic [7:0] line_ctrl;
	logic [7:0] fifo_ctrl;
	logic [7:0] scratchpad;
	logic [1:0] irq_enable;
	udb_format_t fmt;
	logic fifo_mode;
	logic div_write;

	assign div_write = req.wr && (req.addr == UDB_OFF_DIV_LO || req.addr == UDB_OFF_DIV_HI);
	assign fmt = '{wlen: line_ctrl[UDB_LC_WLEN_LSB +: 2], two_stop: line_ctrl[UDB_LC_STOP_BIT],
		par_en: line_ctrl[UDB_LC_PAR_EN_BIT], par_even: line_ctrl[UDB_LC_PAR_EVEN_BIT]};
	assign fifo_mode = fifo_ctrl[UDB_FC_FIFO_EN_BIT];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			divisor <= UDB_DIV_RESET;
			line_ctrl <= UDB_LC_RESET;
			fifo_ctrl <= UDB_FC_RESET;
			scratchpad <= UDB_SCRATCH_RESET;
			irq_enable <= 2'h0;
		end else if (req.wr) begin
			unique case (req.addr)
				UDB_OFF_DIV_LO: divisor[7:0] <= req.wdata;
				UDB_OFF_DIV_HI: divisor[15:8] <= req.wdata;
				UDB_OFF_LINE_CTRL: line_ctrl <= req.wdata;
				UDB_OFF_FIFO_CTRL: fifo_ctrl <= req.wdata;
				UDB_OFF_SCRATCH: scratchpad <= req.wdata;
				UDB_OFF_IRQ_ENABLE: irq_enable <= req.wdata[1:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// Baud generator
	// ****************************************
	logic [15:0] baud_cnt;
	logic tick;

	// Zero divisor treated as one so the tick never stalls
	assign tick = (baud_cnt <= 16'h0001);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			baud_cnt <= UDB_DIV_RESET;
		end else if (div_write) begin
			baud_cnt <= (req.addr == UDB_OFF_DIV_LO) ? {divisor[15:8], req.wdata}
				: {req.wdata, divisor[7:0]};
		end else if (tick) begin
			baud_cnt <= divisor;
		end else begin
			baud_cnt <= baud_cnt - 16'h0001;
		end
	end

	// ****************************************
	// FIFOs
	// ****************************************
	logic [7:0] rx_mem [DEPTH];
	logic [7:0] tx_mem [DEPTH];
	logic [AW:0] rx_wp, rx_rp, tx_wp, tx_rp;
	logic [AW:0] rx_level, tx_level;
	logic rx_push, rx_pop, tx_push, tx_pop;
	logic [7:0] rx_char;

	assign rx_level = rx_wp - rx_rp;
	assign tx_level = tx_wp - tx_rp;
	assign rx_pop = req.rd && req.addr == UDB_OFF_DATA && rx_level != '0;
	// Full transmit FIFO drops the byte
	assign tx_push = req.wr && req.addr == UDB_OFF_DATA && tx_level != (AW + 1)'(DEPTH);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_wp <= '0;
			rx_rp <= '0;
		end else begin
			// Full receive FIFO drops the new character (overrun)
			if (rx_push && rx_level != (AW + 1)'(DEPTH)) begin
				rx_wp <= rx_wp + 1'b1;
			end
			if (rx_pop) begin
				rx_rp <= rx_rp + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rx_push && rx_level != (AW + 1)'(DEPTH)) begin
			rx_mem[rx_wp[AW-1:0]] <= rx_char;
		end
		if (tx_push) begin
			tx_mem[tx_wp[AW-1:0]] <= req.wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_wp <= '0;
			tx_rp <= '0;
		end else begin
			if (tx_push) begin
				tx_wp <= tx_wp + 1'b1;
			end
			if (tx_pop) begin
				tx_rp <= tx_rp + 1'b1;
			end
		end
	end

	// ****************************************
	// Receive shift stage
	// ****************************************
	udb_state_t rx_state;
	logic [3:0] rx_sub;
	logic [2:0] rx_bit;
	logic [7:0] rx_shift;
	logic [2:0] rx_nbits;
	logic [1:0] rx_tail;

	assign rx_nbits = 3'(5 + fmt.wlen - 1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_state <= UDB_IDLE;
			rx_sub <= 4'h0;
			rx_bit <= 3'h0;
			rx_shift <= 8'h00;
			rx_tail <= 2'h0;
			rx_push <= 1'b0;
			rx_char <= 8'h00;
		end else begin
			rx_push <= 1'b0;
			if (tick) begin
				rx_sub <= rx_sub + 4'h1;
				unique case (rx_state)
					UDB_IDLE: begin
						rx_sub <= 4'h0;
						if (!rx) begin
							rx_state <= UDB_START;
						end
					end
					UDB_START: begin
						// Mid-bit check rejects false start pulses
						if (rx_sub == 4'h7) begin
							rx_sub <= 4'h0;
							rx_state <= rx ? UDB_IDLE : UDB_DATA;
							rx_bit <= 3'h0;
						end
					end
					UDB_DATA: begin
						if (rx_sub == 4'hF) begin
							rx_shift <= {rx, rx_shift[7:1]};
							rx_bit <= rx_bit + 3'h1;
							if (rx_bit == rx_nbits) begin
								rx_state <= UDB_TAIL;
								rx_tail <= fmt.par_en ? 2'h1 : 2'h0;
							end
						end
					end
					UDB_TAIL: begin
						// Parity bit skipped, then the character pushed at mid stop bit without sampling rx
						if (rx_sub == 4'hF) begin
							if (rx_tail == 2'h0) begin
								rx_state <= UDB_IDLE;
								rx_push <= 1'b1;
								rx_char <= rx_shift >> (3'h7 - rx_nbits);
							end else begin
								rx_tail <= rx_tail - 2'h1;
							end
						end
					end
				endcase
			end
		end
	end

	// ****************************************
	// Transmit shift stage
	// ****************************************
	udb_state_t tx_state;
	logic [3:0] tx_sub;
	logic [10:0] tx_frame;
	logic [3:0] tx_left;
	logic [7:0] tx_head;
	logic tx_par;
	logic [2:0] tx_nbits;

	assign tx_nbits = 3'(5 + fmt.wlen - 1);
	assign tx_head = tx_mem[tx_rp[AW-1:0]] & ~(8'hFF << (4'(tx_nbits) + 4'h1));
	assign tx_par = ^tx_head ^ ~fmt.par_even;
	// Load only when the stage is idle and a baud tick is due
	assign tx_pop = tick && tx_state == UDB_IDLE && tx_level != '0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_state <= UDB_IDLE;
			tx_sub <= 4'h0;
			tx_frame <= 11'h7FF;
			tx_left <= 4'h0;
			tx <= 1'b1;
		end else if (tick) begin
			tx_sub <= tx_sub + 4'h1;
			unique case (tx_state)
				UDB_IDLE: begin
					tx <= 1'b1;
					if (tx_pop) begin
						tx <= 1'b0;
						// Start bit gets a full sixteen ticks like every bit except the last stop bit, which gets at least seventeen
						tx_sub <= 4'h0;
						tx_state <= UDB_DATA;
						// Data, optional parity, then high stop level
						tx_frame <= fmt.par_en
							? ({3'h0, tx_head} | (11'(tx_par) << (4'(tx_nbits) + 4'h1)))
							| (11'h7FF << (4'(tx_nbits) + 4'h2))
							: {3'h0, tx_head} | (11'h7FF << (4'(tx_nbits) + 4'h1));
						tx_left <= 4'(tx_nbits) + 4'h2 + 4'(fmt.par_en) + 4'(fmt.two_stop);
					end
				end
				UDB_DATA: begin
					if (tx_sub == 4'hF) begin
						tx <= tx_frame[0];
						tx_frame <= {1'b1, tx_frame[10:1]};
						tx_left <= tx_left - 4'h1;
						if (tx_left == 4'h1) begin
							tx_state <= UDB_TAIL;
						end
					end
				end
				UDB_TAIL: begin
					if (tx_sub == 4'hF) begin
						tx_state <= UDB_IDLE;
					end
				end
				default: tx_state <= UDB_IDLE;
			endcase
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	logic [1:0] irq_status;
	logic rx_event, tx_event;
	logic [1:0] clr;
	logic rx_irq_on, tx_irq_on;

	assign rx_irq_on = fifo_mode ? fifo_ctrl[UDB_FC_RX_IRQ_BIT] : 1'b1;
	assign tx_irq_on = fifo_mode ? fifo_ctrl[UDB_FC_TX_IRQ_BIT] : 1'b1;
	assign rx_event = rx_push && rx_irq_on;
	assign tx_event = tx_pop && tx_level == (AW + 1)'(1) && !tx_push && tx_irq_on;
	assign clr = (req.wr && req.addr == UDB_OFF_IRQ_CLEAR) ? req.wdata[1:0] : 2'h0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_status <= 2'h0;
		end else begin
			// Set beats every clear in the same cycle
			if (rx_event) begin
				irq_status[UDB_IRQ_RX_BIT] <= 1'b1;
			end else if (clr[UDB_IRQ_RX_BIT] || (rx_pop && !fifo_mode)) begin
				irq_status[UDB_IRQ_RX_BIT] <= 1'b0;
			end
			if (tx_event) begin
				irq_status[UDB_IRQ_TX_BIT] <= 1'b1;
			end else if (clr[UDB_IRQ_TX_BIT] || (tx_push && !fifo_mode)) begin
				irq_status[UDB_IRQ_TX_BIT] <= 1'b0;
			end
		end
	end

	assign irq = |(irq_status & irq_enable);

	// ****************************************
	// Read data
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			unique case (req.addr)
				UDB_OFF_DATA: rdata <= rx_level != '0 ? rx_mem[rx_rp[AW-1:0]] : 8'h00;
				UDB_OFF_DIV_LO: rdata <= divisor[7:0];
				UDB_OFF_DIV_HI: rdata <= divisor[15:8];
				UDB_OFF_LINE_CTRL: rdata <= line_ctrl;
				UDB_OFF_FIFO_CTRL: rdata <= fifo_ctrl;
				UDB_OFF_SCRATCH: rdata <= scratchpad;
				UDB_OFF_IRQ_STATUS: rdata <= {6'h00, irq_status};
				UDB_OFF_IRQ_ENABLE: rdata <= {6'h00, irq_enable};
				UDB_OFF_FIFO_LEVEL: rdata <= {3'(rx_level >> 2), 5'(tx_level)};
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule : udb_top

// [verif/udb_properties.sv]
module udb_checker
	import udb_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic tx,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] scr;
	logic [7:0] lc;
	logic [7:0] dlo;
	logic [7:0] en;
	logic [7:0] fc;
	logic sent;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// ****************************************
	// Shadow of host writes
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scr <= UDB_SCRATCH_RESET;
			lc <= UDB_LC_RESET;
			dlo <= UDB_DIV_RESET[7:0];
			en <= 8'h00;
			fc <= UDB_FC_RESET;
			sent <= 1'b0;
		end else if (wr) begin
			case (addr)
				UDB_OFF_SCRATCH: scr <= wdata;
				UDB_OFF_LINE_CTRL: lc <= wdata;
				UDB_OFF_DIV_LO: dlo <= wdata;
				UDB_OFF_IRQ_ENABLE: en <= wdata;
				UDB_OFF_FIFO_CTRL: fc <= wdata;
				UDB_OFF_DATA: sent <= 1'b1;
				default: ;
			endcase
		end
	end
	// ****************************************
	// Properties
	// ****************************************
	scratch_back_a: assert property (rd && addr == UDB_OFF_SCRATCH |=> rdata == scr)
		else $error("scratch read mismatch");
	format_back_a: assert property (rd && addr == UDB_OFF_LINE_CTRL |=> rdata[4:0] == lc[4:0])
		else $error("line control read mismatch");
	divisor_back_a: assert property (rd && addr == UDB_OFF_DIV_LO |=> rdata == dlo)
		else $error("divisor read mismatch");
	irq_masked_a: assert property (irq |-> en[1:0] != 2'b00)
		else $error("irq without enable");
	tx_quiet_a: assert property (!sent |-> tx)
		else $error("tx left idle without data");
	start_len_a: assert property ($fell(tx) |-> (!tx) [*8])
		else $error("tx low bit too short");
	write_clear_a: assert property (!fc[0] && en[1:0] == 2'b10 && wr && addr == UDB_OFF_DATA
		|=> !irq)
		else $error("tx irq not cleared by write");
	fifo_quiet_a: assert property (fc[2:0] == 3'b001 && !irq && !wr |=> !irq)
		else $error("irq raised while fifo mode forbids");
endmodule : udb_checker

// [verif/udb_far_node.sv]
module udb_far_node
	import udb_pkg::*;
(
	input wire logic clk,
	input wire logic tx,
	output logic rx
);
	timeunit 1ns;
	timeprecision 1ns;
	int nb = 8;
	logic [7:0] got [$];
	initial rx = 1'b1;
	// Divisor stays 1, so a bit is 16 clocks; idle high between frames
	task automatic send(input logic [7:0] d);
		rx <= 1'b0;
		repeat (16) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			rx <= d[i];
			repeat (16) @(posedge clk);
		end
		rx <= 1'b1;
		repeat (16) @(posedge clk);
	endtask : send
	// Mid-bit sampling; a low stop bit marks the byte unknown
	always begin : catch
		logic [7:0] b;
		@(negedge tx);
		b = 8'h00;
		repeat (8) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			repeat (16) @(posedge clk);
			b[i] = tx;
		end
		repeat (16) @(posedge clk);
		got.push_back(tx ? b : 8'hXX);
	end
endmodule : udb_far_node

// [verif/tb.sv]
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
	$display("ERROR %0t: got %h want %h", $time, a, e); end end
module tb
	import udb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic [7:0] d;
	logic rx;
	logic tx;
	logic irq;
	int errors = 0;
	int n_checks = 0;
	udb_top dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .rx, .tx, .irq);
	udb_far_node far (.clk, .tx, .rx);
	initial forever #20 clk = ~clk;
	// ****************************************
	// Bus and wait helpers
	// ****************************************
	task automatic put(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : put
	task automatic get(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : get
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	task automatic wait_rx(input int n);
		int k = 0;
		while (far.got.size() < n && k < 5000) begin
			@(posedge clk);
			k++;
		end
		if (far.got.size() < n) begin
			errors++;
			$display("ERROR %0t: serial wait timed out", $time);
			stop_test();
		end
	endtask : wait_rx
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_regs();
		get(UDB_OFF_SCRATCH, d); `CHK(d, 8'h00)
		put(UDB_OFF_SCRATCH, 8'h5A);
		get(UDB_OFF_LINE_CTRL, d); `CHK(d, 8'h03)
		get(UDB_OFF_SCRATCH, d); `CHK(d, 8'h5A)
		get(4'hF, d); `CHK(d, 8'h00)
		put(UDB_OFF_DIV_LO, 8'h01);
		put(UDB_OFF_DIV_HI, 8'h00);
		get(UDB_OFF_DIV_LO, d); `CHK(d, 8'h01)
		get(UDB_OFF_DIV_HI, d); `CHK(d, 8'h00)
	endtask : s_regs
	task automatic s_tx();
		put(UDB_OFF_IRQ_ENABLE, 8'h02);
		for (int i = 0; i < 18; i++) put(UDB_OFF_DATA, 8'h10 + 8'(i));
		wait_rx(17);
		repeat (400) @(posedge clk);
		`CHK(far.got.size(), 17)
		for (int i = 0; i < 17; i++) `CHK(far.got[i], 8'h10 + 8'(i))
		`CHK(irq, 1'b1)
		put(UDB_OFF_DATA, 8'hA7);
		`CHK(irq, 1'b0)
		wait_rx(18);
		`CHK(far.got[17], 8'hA7)
	endtask : s_tx
	task automatic s_rx();
		put(UDB_OFF_IRQ_ENABLE, 8'h01);
		for (int i = 0; i < 17; i++) far.send(8'h40 + 8'(i));
		repeat (20) @(posedge clk);
		`CHK(irq, 1'b1)
		get(UDB_OFF_FIFO_LEVEL, d); `CHK(d, 8'h80)
		get(UDB_OFF_DATA, d); `CHK(d, 8'h40)
		`CHK(irq, 1'b0)
		for (int i = 1; i < 16; i++) begin
			get(UDB_OFF_DATA, d); `CHK(d, 8'h40 + 8'(i))
		end
		get(UDB_OFF_DATA, d); `CHK(d, 8'h00)
	endtask : s_rx
	task automatic s_fmt();
		put(UDB_OFF_LINE_CTRL, 8'h02);
		far.nb = 7;
		far.send(8'h55);
		repeat (20) @(posedge clk);
		get(UDB_OFF_DATA, d); `CHK(d, 8'h55)
		put(UDB_OFF_DATA, 8'hD5);
		wait_rx(19);
		`CHK(far.got[18], 8'h55)
		far.nb = 8;
		put(UDB_OFF_LINE_CTRL, 8'h03);
	endtask : s_fmt
	task automatic s_fifo();
		put(UDB_OFF_IRQ_CLEAR, 8'h03);
		put(UDB_OFF_FIFO_CTRL, 8'h01);
		far.send(8'h21);
		repeat (20) @(posedge clk);
		`CHK(irq, 1'b0)
		put(UDB_OFF_FIFO_CTRL, 8'h03);
		far.send(8'h22);
		repeat (20) @(posedge clk);
		`CHK(irq, 1'b1)
		get(UDB_OFF_DATA, d);
		get(UDB_OFF_DATA, d); `CHK(d, 8'h22)
		`CHK(irq, 1'b1)
		put(UDB_OFF_IRQ_CLEAR, 8'h01);
		`CHK(irq, 1'b0)
	endtask : s_fifo
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		s_regs();
		s_tx();
		s_rx();
		s_fmt();
		s_fifo();
		stop_test();
	end
endmodule : tb
bind udb_top udb_checker chk (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .tx, .irq);
